// ### verilog/program_memory_guard_and_serial_entry.v
// Program memory protection gate and serial programming test mode entry.
`timescale 1ns/1ps
`include "pm_guard_consts.vh"
// Summary of operation
// - All-zero protection mode bits select code-protected mode.
// - Protected: instructions fetched on chip may still read and write program memory.
// - Protected: accesses by instructions fetched outside internal memory are blocked.
// - Unprotected: internal program memory may be read out externally for verification.
// - Test mode entry needs test pin high first, then master clear pin.
// - On entry the program counter is loaded with the boot ROM start.
// - In test mode the device clock comes from the programming clock pin.
// - Boot code sets up the serial port on data and clock lines.
module program_memory_guard_and_serial_entry #(
  parameter [15:0] internal_top = `INTERNAL_TOP_DEFAULT
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [2:0]  protection_mode_bits,
  input  wire [15:0] fetch_address,
  input  wire        mem_read_request,
  input  wire        mem_write_request,
  input  wire        external_readout_request,
  input  wire        test_pin_high,
  input  wire        master_clear_program_voltage_pin,
  input  wire        programming_clock_pin,
  input  wire        serial_clock_line,
  input  wire        serial_data_line_in,
  output reg         serial_data_line_out,
  output reg         serial_data_line_oe,
  output reg         mem_read_grant,
  output reg         mem_write_grant,
  output reg         external_readout_grant,
  output reg         code_protected,
  output reg         test_mode,
  output reg         pc_load,
  output reg  [15:0] pc_value,
  output reg         device_clock_tick,
  output reg         serial_ready,
  output reg  [7:0]  command_byte,
  output reg         command_valid
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
  reg [1:0] sync_test;
  reg [1:0] sync_mclr;
  reg [1:0] sync_pclk;
  reg [1:0] sync_sck;
  reg [1:0] sync_sdi;
  reg       pclk_last;
  reg       sck_last;
  always @(posedge clk) begin
    if (reset) begin
      sync_test <= 2'h0;
      sync_mclr <= 2'h0;
      sync_pclk <= 2'h0;
      sync_sck  <= 2'h0;
      sync_sdi  <= 2'h0;
      pclk_last <= 1'h0;
      sck_last  <= 1'h0;
    end else begin
      sync_test <= {sync_test[0], test_pin_high};
      sync_mclr <= {sync_mclr[0], master_clear_program_voltage_pin};
      sync_pclk <= {sync_pclk[0], programming_clock_pin};
      sync_sck  <= {sync_sck[0], serial_clock_line};
      sync_sdi  <= {sync_sdi[0], serial_data_line_in};
      pclk_last <= sync_pclk[1];
      sck_last  <= sync_sck[1];
    end
  end
  wire pclk_rise = sync_pclk[1] & ~pclk_last;
  wire sck_rise  = sync_sck[1] & ~sck_last;

// ----------------------------------------------------------------
// Protection gate
// ----------------------------------------------------------------
  wire protect  = (protection_mode_bits == `PROTECT_PATTERN);
  wire internal = (fetch_address <= internal_top);

// ----------------------------------------------------------------
// Protection status flag
// ----------------------------------------------------------------
  // The flag is registered so that it lines up with the grants below.
  always @(posedge clk) begin
    if (reset) begin
      code_protected <= 1'h0;
    end else begin
      code_protected <= protect;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      mem_read_grant         <= 1'h0;
      mem_write_grant        <= 1'h0;
      external_readout_grant <= 1'h0;
    end else begin
      // Outside fetches only reach memory when protection is off.
      mem_read_grant         <= mem_read_request & (internal | ~protect);
      mem_write_grant        <= mem_write_request & (internal | ~protect);
      external_readout_grant <= external_readout_request & ~protect;
    end
  end

// ----------------------------------------------------------------
// Test mode entry
// ----------------------------------------------------------------
  localparam st_idle  = 2'h0;
  localparam st_armed = 2'h1;
  localparam st_test  = 2'h2;
  localparam st_block = 2'h3;
  reg [1:0] state;
  reg [1:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      st_idle: begin
        if (sync_mclr[1])
          next_state = st_block;
        else if (sync_test[1])
          next_state = st_armed;
      end
      st_armed: begin
        if (!sync_test[1])
          next_state = st_idle;
        else if (sync_mclr[1])
          next_state = st_test;
      end
      st_test: begin
        if (!sync_test[1] || !sync_mclr[1])
          next_state = st_idle;
      end
      st_block: begin
        // Wrong order: wait until both pins drop before trying again.
        if (!sync_test[1] && !sync_mclr[1])
          next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  reg [7:0] boot_count;
  always @(posedge clk) begin
    if (reset) begin
      state     <= st_idle;
      test_mode <= 1'h0;
      pc_load   <= 1'h0;
      pc_value  <= 16'h0000;
    end else begin
      state     <= next_state;
      test_mode <= (next_state == st_test);
      pc_load   <= (state == st_armed) && (next_state == st_test);
      if ((state == st_armed) && (next_state == st_test))
        pc_value <= `BOOT_START;
    end
  end

// ----------------------------------------------------------------
// Device clock from the programming clock pin
// ----------------------------------------------------------------
  // Only programming clock edges count here; the normal oscillator plays no part.
  always @(posedge clk) begin
    if (reset) begin
      device_clock_tick <= 1'h0;
    end else begin
      device_clock_tick <= (state == st_test) & pclk_rise;
    end
  end

// ----------------------------------------------------------------
// Boot delay before the serial port is ready
// ----------------------------------------------------------------
  // The counter saturates so that a slow programmer cannot wrap it to zero.
  always @(posedge clk) begin
    if (reset) begin
      boot_count   <= 8'h00;
      serial_ready <= 1'h0;
    end else if (state != st_test) begin
      boot_count   <= 8'h00;
      serial_ready <= 1'h0;
    end else if (pclk_rise && boot_count != `BOOT_WAIT_CLOCKS) begin
      boot_count <= boot_count + 8'h01;
    end else if (boot_count == `BOOT_WAIT_CLOCKS) begin
      serial_ready <= 1'h1;
    end
  end

// ----------------------------------------------------------------
// Serial command receiver
// ----------------------------------------------------------------
  reg [7:0] shift;
  reg [3:0] bit_count;
  always @(posedge clk) begin
    if (reset) begin
      shift                <= 8'h00;
      bit_count            <= 4'h0;
      command_byte         <= 8'h00;
      command_valid        <= 1'h0;
    end else begin
      command_valid        <= 1'h0;
      // Bits before setup are dropped so the first byte stays aligned.
      if (!serial_ready) begin
        bit_count <= 4'h0;
      end else if (sck_rise) begin
        shift <= {sync_sdi[1], shift[7:1]};
        if (bit_count == `SHIFT_BITS - 4'h1) begin
          bit_count     <= 4'h0;
          command_byte  <= {sync_sdi[1], shift[7:1]};
          command_valid <= 1'h1;
        end else begin
          bit_count <= bit_count + 4'h1;
        end
      end
    end
  end

// ----------------------------------------------------------------
// Serial data line driver
// ----------------------------------------------------------------
  // The block only receives, so the data line is never driven from here.
  always @(posedge clk) begin
    if (reset) begin
      serial_data_line_out <= 1'h0;
      serial_data_line_oe  <= 1'h0;
    end else begin
      serial_data_line_out <= 1'h0;
      serial_data_line_oe  <= 1'h0;
    end
  end
endmodule

// ### pkg/pm_guard_consts.vh
// Constants for the program memory guard and serial entry block.
`ifndef PM_GUARD_CONSTS_VH
`define PM_GUARD_CONSTS_VH
`define PROTECT_PATTERN      3'h0
`define BOOT_START           16'hff60
`define INTERNAL_TOP_DEFAULT 16'hfdff
`define BOOT_WAIT_CLOCKS     8'h50
`define SHIFT_BITS           4'h8
`endif

// ### test/pm_guard_sva.sv
// Assertions for the program memory guard and serial entry block.
`timescale 1ns/1ps
module pm_guard_sva #(parameter [15:0] internal_top = 16'hfdff) (
  input wire clk, reset, mem_read_request, mem_write_request, external_readout_request, test_pin_high,
  input wire master_clear_program_voltage_pin, mem_read_grant, mem_write_grant, external_readout_grant,
  input wire code_protected, test_mode, pc_load, serial_ready, command_valid,
  input wire [2:0] protection_mode_bits,
  input wire [15:0] fetch_address, pc_value);
  wire p0 = protection_mode_bits == 3'h0;
  wire ok = !p0 || fetch_address <= internal_top;
  wire xok = external_readout_request && !p0;
  wire tp = test_pin_high;
  wire mc = master_clear_program_voltage_pin;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_armed; tp && !mc; endsequence
  sequence s_raise; tp && $rose(mc); endsequence
  a_protect_mode: assert property ($stable(p0) |=> code_protected == $past(p0)) else $error("mode");
  a_gate_pass: assert property (ok |=> mem_read_grant == $past(mem_read_request)
    && mem_write_grant == $past(mem_write_request)) else $error("pass");
  a_gate_block: assert property (!ok |=> !mem_read_grant && !mem_write_grant) else $error("block");
  a_readout_gate: assert property (1 |=> external_readout_grant == $past(xok)) else $error("readout");
  a_entry_good: assert property (s_armed [*4] ##1 s_raise ##1 (tp && mc) [*2]
    |-> ##[0:6] $rose(test_mode)) else $error("entry");
  a_entry_bad: assert property (!tp && $rose(mc) |=> !test_mode [*8]) else $error("order");
  a_boot_pc: assert property ($rose(test_mode) |-> ##[0:1] pc_load && pc_value == 16'hff60)
    else $error("pc");
  a_early_drop: assert property (command_valid |-> $past(serial_ready)) else $error("early");
endmodule
bind program_memory_guard_and_serial_entry pm_guard_sva #(.internal_top(internal_top)) i_pm_guard_sva (.*);

// ### test/programmer_model.sv
// Behavioural model of the external serial programmer.
`timescale 1ns/1ps
module programmer_model (
  output logic test_pin_high,
  output logic master_clear_program_voltage_pin,
  output logic programming_clock_pin,
  output logic serial_clock_line,
  output logic serial_data_line_in);
  logic run = 1'b0;
  initial {test_pin_high, master_clear_program_voltage_pin, programming_clock_pin} = 3'h0;
  initial {serial_clock_line, serial_data_line_in} = 2'h0;
  // The device clock stands still between sessions.
  always #400 programming_clock_pin = run & ~programming_clock_pin;
  task automatic enter(input logic good);
    if (good) test_pin_high = 1'b1;
    else master_clear_program_voltage_pin = 1'b1;
    #1000 {test_pin_high, master_clear_program_voltage_pin, run} = 3'h7;
  endtask
  task automatic leave;
    run = 1'b0;
    #1000 {test_pin_high, master_clear_program_voltage_pin} = 2'h0;
  endtask
  task automatic boot_wait;
    repeat (80) @(posedge programming_clock_pin);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_data_line_in = b[i];
      #400 serial_clock_line = 1'b1;
      #400 serial_clock_line = 1'b0;
    end
    // A released data line must not keep showing the last bit.
    serial_data_line_in = ~serial_data_line_in;
  endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the program memory guard and serial entry block.
`timescale 1ns/1ps
`include "pm_guard_consts.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
  logic clk, reset, mem_read_request, mem_write_request, external_readout_request, serial_data_line_out;
  logic serial_data_line_oe, mem_read_grant, mem_write_grant, external_readout_grant, code_protected, test_mode;
  logic pc_load, device_clock_tick, serial_ready, command_valid;
  logic [2:0] protection_mode_bits, e;
  logic [15:0] fetch_address, pc_value;
  logic [7:0] command_byte, got, b;
  logic [31:0] rs = 32'd53;
  wire test_pin_high, master_clear_program_voltage_pin, programming_clock_pin, serial_clock_line, serial_data_line_in;
  int bad_count, samples_checked, cyc, nv, ticks;
  program_memory_guard_and_serial_entry i_program_memory_guard_and_serial_entry (.*);
  programmer_model i_programmer_model (.*);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [2:0] gate(input logic [2:0] m, input logic [15:0] a, input logic [2:0] q);
    return q & {{2{m != 3'h0 || a <= `INTERNAL_TOP_DEFAULT}}, m != 3'h0};
  endfunction
  task automatic wrap_up;
    $display("%0d checks %0d bad", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (command_valid) got <= command_byte;
    if (command_valid) nv++;
    if (device_clock_tick) ticks++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    reset = 1'b1;
    {mem_read_request, mem_write_request, external_readout_request, protection_mode_bits, fetch_address} = '0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 300; i++) begin
      rs = xs(rs);
      {mem_read_request, mem_write_request, external_readout_request} = rs[2:0];
      protection_mode_bits = rs[3] ? 3'h0 : rs[6:4];
      // Half the addresses sit on either side of the internal bound.
      fetch_address = rs[7] ? `INTERNAL_TOP_DEFAULT - 16'h2 + rs[10:8] : rs[31:16];
      e = gate(protection_mode_bits, fetch_address, rs[2:0]);
      @(negedge clk);
      `CHK({mem_read_grant, mem_write_grant, external_readout_grant}, e)
      `CHK(code_protected, protection_mode_bits == 3'h0)
    end
    $display("gate test done");
    i_programmer_model.enter(1'b0);
    repeat (30) @(negedge clk);
    `CHK(test_mode, 1'b0)
    `CHK({ticks, serial_data_line_oe, serial_data_line_out}, 34'h0)
    i_programmer_model.leave();
    repeat (10) @(negedge clk);
    i_programmer_model.enter(1'b1);
    for (int i = 0; i < 20 && !pc_load; i++) @(negedge clk);
    `CHK({pc_load, pc_value}, {1'b1, `BOOT_START})
    $display("entry test done");
    nv = 0;
    i_programmer_model.send(8'h5a);
    repeat (10) @(negedge clk);
    `CHK({test_mode, nv}, {1'b1, 32'h0})
    i_programmer_model.boot_wait();
    repeat (10) @(negedge clk);
    `CHK({serial_ready, serial_data_line_oe}, 2'h2)
    `CHK(ticks >= 80, 1'b1)
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      b = i == 0 ? 8'h00 : i == 1 ? 8'h81 : rs[7:0];
      i_programmer_model.send(b);
      repeat (10) @(negedge clk);
      `CHK({nv, got}, {i + 1, b})
      `CHK({serial_data_line_oe, serial_data_line_out}, 2'h0)
    end
    $display("serial test done");
    i_programmer_model.leave();
    repeat (10) @(negedge clk);
    `CHK({test_mode, serial_ready}, 2'h0)
    wrap_up;
  end
endmodule
